// *** rtl/addr_gen.sv ***
`timescale 1ns/100ps
`include "exec_flags_regs.svh"

// Segment and offset to registered physical address
module addr_gen #(
  parameter int SEG_W = 16,
  parameter int ADDR_W = 20
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic [SEG_W-1:0] seg_i,
  input wire logic [SEG_W-1:0] off_i,
  output logic [ADDR_W-1:0] phys_addr_o,
  output logic phys_valid_o
);

  logic [ADDR_W-1:0] seg_scaled; // Segment times sixteen
  logic [ADDR_W-1:0] off_wide;
  logic [ADDR_W-1:0] sum_wrap; // Wraps past the top of memory

  assign seg_scaled = ADDR_W'({seg_i, {`SEG_SHIFT{1'b0}}});
  assign off_wide = ADDR_W'(off_i);
  assign sum_wrap = seg_scaled + off_wide;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      phys_addr_o <= `PHYS_RESET;
      phys_valid_o <= 1'b0;
    end else begin
      phys_valid_o <= req_i;
      if (req_i) begin
        phys_addr_o <= sum_wrap;
      end
    end
  end

endmodule

// *** rtl/exec_flags_and_address_gen.sv ***
//
// Contract
// - Aux flag on low nibble carry/borrow
// - Parity flag set on even low byte
// - Carry flag on msb carry or borrow
// - Form 20-bit address for bus unit
// - Segment and offset, both 16 bits
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "exec_flags_regs.svh"

module exec_flags_and_address_gen #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 20,
  parameter int REG_AW = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Operation from the execution sequencer
  input wire logic op_valid_i,
  input wire exec_flags_pkg::alu_op_type op_code_i,
  input wire logic op_byte_i,
  input wire logic [DATA_W-1:0] op_a_i,
  input wire logic [DATA_W-1:0] op_b_i,
  output logic [DATA_W-1:0] result_o,
  output logic result_valid_o,
  output logic [DATA_W-1:0] flags_o,
  // Memory reference from the core
  input wire logic mem_req_i,
  input wire logic [DATA_W-1:0] seg_i,
  input wire logic [DATA_W-1:0] off_i,
  output logic [ADDR_W-1:0] phys_addr_o,
  output logic phys_valid_o,
  output exec_flags_pkg::addr_src_type phys_src_o,
  // Register port
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o
);
  import exec_flags_pkg::*;
  // Three parts: flag capture, address arbitration, register port
  // All state sits on core_clk_i; there is no second domain here

  // Status flags, stored with reserved bits at zero
  logic [DATA_W-1:0] flags_reg;
  logic [DATA_W-1:0] flags_next;
  // Control: freeze bit holds flags against hardware updates
  logic [DATA_W-1:0] ctrl_reg;
  // Last result for software inspection
  logic [DATA_W-1:0] last_result_reg;
  // Software-supplied segment and offset
  logic [DATA_W-1:0] soft_seg_reg;
  logic [DATA_W-1:0] soft_off_reg;
  // Pending software reference, waits while the core uses the unit
  logic soft_pend_reg;
  logic soft_pend_next;
  // Source of the address now being formed
  addr_src_type src_reg;
  // Last address seen by software
  logic [ADDR_W-1:0] phys_seen_reg;
  // Read data register, valid only one cycle after a read
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Calculator outputs are combinational and only ever reach
  // the outside through the flops below
  // Datapath outputs of the flag calculator
  logic [DATA_W-1:0] calc_result;
  logic calc_carry;
  logic calc_aux;
  logic calc_parity;

  // Address generator hookup
  // Arbitrated request and operands toward the address former
  logic agen_req;
  logic [DATA_W-1:0] agen_seg;
  logic [DATA_W-1:0] agen_off;
  logic [ADDR_W-1:0] agen_addr;
  logic agen_valid;

  // Flat compare per offset; the port is small enough that
  // a case table would only add muxing depth
  // Register decode strobes
  wire hit_flags = (reg_addr_i == `OFF_FLAGS);
  wire hit_ctrl = (reg_addr_i == `OFF_CTRL);
  wire hit_result = (reg_addr_i == `OFF_RESULT);
  wire hit_seg = (reg_addr_i == `OFF_SEG);
  wire hit_ofs = (reg_addr_i == `OFF_OFS);
  wire hit_phys_lo = (reg_addr_i == `OFF_PHYS_LO);
  wire hit_phys_hi = (reg_addr_i == `OFF_PHYS_HI);
  wire wr_flags = reg_wr_i & hit_flags;
  wire wr_ctrl = reg_wr_i & hit_ctrl;
  wire wr_seg = reg_wr_i & hit_seg;
  // Writing the offset launches a software reference
  wire wr_ofs = reg_wr_i & hit_ofs;

  // Freeze gives software a stable flag word to inspect or patch;
  // results keep flowing so the datapath never stalls
  // Hardware flag update allowed unless software froze it
  wire freeze = ctrl_reg[`CTRL_FREEZE_BIT];
  wire flag_upd = op_valid_i & ~freeze;

  // Hazard: a core that requests every cycle starves the software
  // reference; software polls the address readback to see it land
  // Core references always win the address unit
  wire core_go = mem_req_i;
  wire soft_go = (soft_pend_reg | wr_ofs) & ~mem_req_i;

  // Carry-in comes from the stored carry bit, so chained ops
  // with carry or borrow see the previous result
  // Arithmetic and flag derivation
  flag_calc #(
    .WIDTH(DATA_W)
  ) u_flag_calc (
    .op_code_i(op_code_i),
    .op_byte_i(op_byte_i),
    .carry_in_i(flags_reg[`CARRY_OUT_FLAG_BIT]),
    .op_a_i(op_a_i),
    .op_b_i(op_b_i),
    .result_o(calc_result),
    .carry_o(calc_carry),
    .aux_o(calc_aux),
    .parity_o(calc_parity)
  );

  // A core request brings its own segment and offset; otherwise
  // the software copies feed the former
  // both halves feed address formation
  assign agen_req = core_go | soft_go;
  assign agen_seg = core_go ? seg_i : soft_seg_reg;
  // Offset written this cycle is used at once
  assign agen_off = core_go ? off_i
                  : (wr_ofs ? reg_wdata_i : soft_off_reg);

  // One cycle of latency: the address leaves from a flop, so the
  // bus unit never sees a path from the segment or offset inputs
  // Physical address former
  addr_gen #(
    .SEG_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_addr_gen (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .req_i(agen_req),
    .seg_i(agen_seg),
    .off_i(agen_off),
    .phys_addr_o(agen_addr),
    .phys_valid_o(agen_valid)
  );

  // Per-bit priority: a same-cycle software write still lands on
  // the bits that the hardware does not own
  // Flag next value: software write first, hardware on top
  always_comb begin
    flags_next = flags_reg;
    // Software write reaches only the defined bits
    if (wr_flags) begin
      flags_next = reg_wdata_i & `FLAGS_WR_MASK;
    end
    // Hardware wins so a same-cycle result is never lost
    if (flag_upd) begin
      flags_next[`AUX_FLAG_BIT] = calc_aux;
      flags_next[`PARITY_FLAG_BIT] = calc_parity;
      flags_next[`CARRY_OUT_FLAG_BIT] = calc_carry;
    end
  end

  // Only one reference can wait; a second offset write before
  // service replaces the offset, the newest software intent
  // Pending software reference bookkeeping
  always_comb begin
    soft_pend_next = soft_pend_reg;
    if (wr_ofs) begin
      soft_pend_next = 1'b1;
    end
    // Served in any cycle the core leaves free
    if (soft_go) begin
      soft_pend_next = 1'b0;
    end
  end

  // Reads have no side effects, so software may poll freely
  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rdata_next = `WORD_RESET;
    if (reg_rd_i) begin
      if (hit_flags) begin
        rdata_next = flags_reg;
      end else if (hit_ctrl) begin
        rdata_next = ctrl_reg;
      end else if (hit_result) begin
        rdata_next = last_result_reg;
      end else if (hit_seg) begin
        rdata_next = soft_seg_reg;
      end else if (hit_ofs) begin
        rdata_next = soft_off_reg;
      end else if (hit_phys_lo) begin
        rdata_next = phys_seen_reg[DATA_W-1:0];
      end else if (hit_phys_hi) begin
        // High nibble of the address in the low bits
        rdata_next = DATA_W'(phys_seen_reg[ADDR_W-1:DATA_W]);
      end
    end
  end

  // Only the freeze bit of the control word is stored; the rest
  // read zero so later fields do not upset older software
  // Flag and control storage
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      flags_reg <= `FLAGS_RESET;
      ctrl_reg <= `CTRL_RESET;
    end else begin
      flags_reg <= flags_next;
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata_i & DATA_W'(1 << `CTRL_FREEZE_BIT);
      end
    end
  end

  // Byte ops pass the full datapath word; software that wants
  // only the byte masks the upper half itself
  // Result register, data leave from flops
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      result_o <= `WORD_RESET;
      result_valid_o <= 1'b0;
      last_result_reg <= `WORD_RESET;
    end else begin
      result_valid_o <= op_valid_i;
      // Compare updates flags only, result stays
      if (op_valid_i && op_code_i != OP_CMP) begin
        result_o <= calc_result;
        last_result_reg <= calc_result;
      end
    end
  end

  // Segment and offset copies stay readable after service, so
  // software can confirm what it asked for
  // Software address inputs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      soft_seg_reg <= `WORD_RESET;
      soft_off_reg <= `WORD_RESET;
      soft_pend_reg <= 1'b0;
    end else begin
      soft_pend_reg <= soft_pend_next;
      if (wr_seg) begin
        soft_seg_reg <= reg_wdata_i;
      end
      if (wr_ofs) begin
        soft_off_reg <= reg_wdata_i;
      end
    end
  end

  // Source is taken on the same edge as the address, so both
  // always describe the same transfer
  // Track which source the registered address belongs to
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      src_reg <= SRC_IDLE;
    end else if (core_go) begin
      src_reg <= SRC_CORE;
    end else if (soft_go) begin
      src_reg <= SRC_SOFT;
    end else begin
      src_reg <= SRC_IDLE;
    end
  end

  // Core and software addresses both land here; software sees
  // the latest one, not necessarily its own
  // Latest formed address kept for software reads
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      phys_seen_reg <= `PHYS_RESET;
    end else if (agen_valid) begin
      phys_seen_reg <= agen_addr;
    end
  end

  // Zero outside the answer cycle keeps a shared read bus quiet
  // Read data stand one cycle, zero otherwise
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_reg <= `WORD_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Address outputs come straight from the former's flops
  // address handed to bus unit
  assign phys_addr_o = agen_addr;
  assign phys_valid_o = agen_valid;
  // Idle when no address is valid
  assign phys_src_o = agen_valid ? src_reg : SRC_IDLE;
  assign flags_o = flags_reg;
  assign reg_rdata_o = rdata_reg;

endmodule

// *** rtl/exec_flags_pkg.sv ***
package exec_flags_pkg;

  // Operations offered by the flag datapath
  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_ADC = 3'b001,
    OP_SUB = 3'b010,
    OP_SBB = 3'b011,
    OP_AND = 3'b100,
    OP_OR = 3'b101,
    OP_XOR = 3'b110,
    OP_CMP = 3'b111
  } alu_op_type;

  // Source of a physical address request
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_CORE = 2'b01,
    SRC_SOFT = 2'b10
  } addr_src_type;

endpackage

// *** rtl/exec_flags_regs.svh ***
`ifndef EXEC_FLAGS_REGS_SVH
`define EXEC_FLAGS_REGS_SVH

// Register offsets on the 16-bit register port
`define OFF_FLAGS 8'h00
`define OFF_CTRL 8'h02
`define OFF_RESULT 8'h04
`define OFF_SEG 8'h06
`define OFF_OFS 8'h08
`define OFF_PHYS_LO 8'h0a
`define OFF_PHYS_HI 8'h0c

// Status flag bit positions
`define CARRY_OUT_FLAG_BIT 0
`define PARITY_FLAG_BIT 2
`define AUX_FLAG_BIT 4

// Reset values
`define FLAGS_RESET 16'h0000
`define CTRL_RESET 16'h0000
`define WORD_RESET 16'h0000
`define PHYS_RESET 20'h00000

// Writable flag bits: 11..6, 4, 2, 0; reserved bits read zero
`define FLAGS_WR_MASK 16'h0fd5

// Control register fields
`define CTRL_FREEZE_BIT 0

// Arithmetic bit positions
`define NIBBLE_CARRY_BIT 4
`define BYTE_CARRY_BIT 8
`define WORD_CARRY_BIT 16
`define LOW_BYTE_MSB 7

// Segment scaling for address formation
`define SEG_SHIFT 4

`endif

// *** rtl/flag_calc.sv ***
`timescale 1ns/100ps
`include "exec_flags_regs.svh"

// Combinational result and low-order flag derivation
module flag_calc #(
  parameter int WIDTH = 16
) (
  input wire exec_flags_pkg::alu_op_type op_code_i,
  input wire logic op_byte_i,
  input wire logic carry_in_i,
  input wire logic [WIDTH-1:0] op_a_i,
  input wire logic [WIDTH-1:0] op_b_i,
  output logic [WIDTH-1:0] result_o,
  output logic carry_o,
  output logic aux_o,
  output logic parity_o
);
  import exec_flags_pkg::*;

  logic [WIDTH:0] ext_a; // Zero-extended operands
  logic [WIDTH:0] ext_b;
  logic [WIDTH:0] ext_c; // Carry or borrow in
  logic [WIDTH:0] raw; // One bit wider to catch carry
  logic arith; // Arithmetic op, carry meaningful
  logic use_cin;

  always_comb begin
    // Byte ops look only at the low byte
    if (op_byte_i) begin
      ext_a = {{(WIDTH-7){1'b0}}, op_a_i[`LOW_BYTE_MSB:0]};
      ext_b = {{(WIDTH-7){1'b0}}, op_b_i[`LOW_BYTE_MSB:0]};
    end else begin
      ext_a = {1'b0, op_a_i};
      ext_b = {1'b0, op_b_i};
    end
    use_cin = (op_code_i == OP_ADC) || (op_code_i == OP_SBB);
    ext_c = {{WIDTH{1'b0}}, use_cin & carry_in_i};
    arith = 1'b1;
    raw = {(WIDTH+1){1'b0}};
    unique case (op_code_i)
      OP_ADD, OP_ADC: begin
        raw = ext_a + ext_b + ext_c;
      end
      // Borrow shows as ones above the operand width
      OP_SUB, OP_SBB, OP_CMP: begin
        raw = ext_a - ext_b - ext_c;
      end
      OP_AND: begin
        raw = ext_a & ext_b;
        arith = 1'b0;
      end
      OP_OR: begin
        raw = ext_a | ext_b;
        arith = 1'b0;
      end
      OP_XOR: begin
        raw = ext_a ^ ext_b;
        arith = 1'b0;
      end
    endcase
    result_o = raw[WIDTH-1:0];
    carry_o = arith & (op_byte_i ? raw[`BYTE_CARRY_BIT]
                                 : raw[`WORD_CARRY_BIT]);
    aux_o = arith & (ext_a[`NIBBLE_CARRY_BIT] ^ ext_b[`NIBBLE_CARRY_BIT]
                     ^ raw[`NIBBLE_CARRY_BIT]);
    parity_o = ~^raw[`LOW_BYTE_MSB:0];
  end

endmodule

// *** verif/bus_unit_model.sv ***
`timescale 1ns/100ps

// Far-side bus unit: takes each physical address handed over
module bus_unit_model (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [19:0] phys_addr_i,
  input wire logic phys_valid_i,
  output logic [19:0] last_addr_o,
  output logic [7:0] count_o
);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count_o <= 8'h00;
    end else if (phys_valid_i) begin
      last_addr_o <= phys_addr_i;
      count_o <= count_o + 8'h01;
    end
  end
endmodule

// *** verif/exec_flags_and_address_gen_tb_top.sv ***
`timescale 1ns/100ps
`include "exec_flags_regs.svh"

module exec_flags_and_address_gen_tb_top;
  import exec_flags_pkg::*;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic op_valid_i = 1'b0;
  alu_op_type op_code_i = OP_ADD;
  logic op_byte_i = 1'b0;
  logic [15:0] op_a_i = 16'h0000;
  logic [15:0] op_b_i = 16'h0000;
  logic mem_req_i = 1'b0;
  logic [15:0] seg_i = 16'h0000;
  logic [15:0] off_i = 16'h0000;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] result_o, flags_o, reg_rdata_o;
  logic result_valid_o, phys_valid_o;
  logic [19:0] phys_addr_o, last_addr;
  addr_src_type phys_src_o;
  logic [7:0] seen_count; // Addresses taken by the bus unit
  int fail_count = 0;
  int compares = 0;

  always #2 core_clk_i = ~core_clk_i;

  exec_flags_and_address_gen exec_flags_and_address_gen_i (
    .core_clk_i, .srst_i, .op_valid_i, .op_code_i, .op_byte_i, .op_a_i,
    .op_b_i, .result_o, .result_valid_o, .flags_o, .mem_req_i, .seg_i,
    .off_i, .phys_addr_o, .phys_valid_o, .phys_src_o, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  bus_unit_model bus_unit_model_i (.core_clk_i, .srst_i,
    .phys_addr_i(phys_addr_o), .phys_valid_i(phys_valid_o),
    .last_addr_o(last_addr), .count_o(seen_count));

  // Compare, count, report at once
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(20'(reg_rdata_o), 20'(e));
  endtask

  // One operation, answer looked at one cycle later
  task automatic op(input alu_op_type c, input logic b,
                    input logic [15:0] x, y, r, f);
    @(posedge core_clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_byte_i <= b;
    op_a_i <= x;
    op_b_i <= y;
    @(posedge core_clk_i);
    op_valid_i <= 1'b0;
    #1;
    chk(20'(result_valid_o), 20'h00001);
    chk(20'(result_o), 20'(r));
    chk(20'(flags_o), 20'(f));
  endtask

  // Core memory reference
  task automatic mem(input logic [15:0] s, o, input logic [19:0] e);
    @(posedge core_clk_i);
    mem_req_i <= 1'b1;
    seg_i <= s;
    off_i <= o;
    @(posedge core_clk_i);
    mem_req_i <= 1'b0;
    #1;
    chk(20'(phys_valid_o), 20'h00001);
    chk(phys_addr_o, e);
    chk(20'(phys_src_o), 20'(SRC_CORE));
  endtask

  initial begin
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(`OFF_FLAGS, 16'h0000);
    rd(8'h20, 16'h0000);
    op(OP_ADD, 1'b0, 16'h000f, 16'h0001, 16'h0010, 16'h0010);
    op(OP_ADD, 1'b0, 16'hffff, 16'h0001, 16'h0000, 16'h0015);
    op(OP_SUB, 1'b0, 16'h0010, 16'h0001, 16'h000f, 16'h0014);
    op(OP_SUB, 1'b0, 16'h0000, 16'h0001, 16'hffff, 16'h0015);
    op(OP_ADC, 1'b0, 16'h0001, 16'h0001, 16'h0003, 16'h0004);
    op(OP_SBB, 1'b0, 16'h0005, 16'h0001, 16'h0004, 16'h0000);
    op(OP_ADD, 1'b1, 16'h0080, 16'h0080, 16'h0100, 16'h0005);
    op(OP_SBB, 1'b1, 16'h0000, 16'h0001, 16'hfffe, 16'h0011);
    op(OP_AND, 1'b0, 16'hff0f, 16'h00f0, 16'h0000, 16'h0004);
    op(OP_OR, 1'b0, 16'h0001, 16'h0002, 16'h0003, 16'h0004);
    op(OP_XOR, 1'b0, 16'h00ff, 16'h0001, 16'h00fe, 16'h0000);
    op(OP_CMP, 1'b0, 16'h0001, 16'h0002, 16'h00fe, 16'h0015);
    rd(`OFF_FLAGS, 16'h0015);
    wr(`OFF_FLAGS, 16'hffff);
    rd(`OFF_FLAGS, 16'h0fd5);
    // Frozen flags ignore the operation, result still moves
    wr(`OFF_CTRL, 16'h0001);
    rd(`OFF_CTRL, 16'h0001);
    op(OP_ADD, 1'b0, 16'h0001, 16'h0001, 16'h0002, 16'h0fd5);
    rd(`OFF_RESULT, 16'h0002);
    wr(`OFF_CTRL, 16'h0000);
    mem(16'h1234, 16'h0005, 20'h12345);
    mem(16'hffff, 16'h0010, 20'h00000);
    mem(16'hf000, 16'hffff, 20'hfffff);
    // Software reference launched by the offset write
    wr(`OFF_SEG, 16'h0100);
    wr(`OFF_OFS, 16'h0020);
    #1;
    for (int i = 0; i < 8 && phys_valid_o !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (phys_valid_o !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    chk(phys_addr_o, 20'h01020);
    chk(20'(phys_src_o), 20'(SRC_SOFT));
    rd(`OFF_PHYS_LO, 16'h1020);
    // Read data must drop back to zero one cycle later
    @(posedge core_clk_i);
    #1;
    chk(20'(reg_rdata_o), 20'h00000);
    rd(`OFF_PHYS_HI, 16'h0000);
    // Core reference beats a same-cycle offset write; software waits
    @(posedge core_clk_i);
    mem_req_i <= 1'b1;
    seg_i <= 16'h0002;
    off_i <= 16'h0003;
    reg_wr_i <= 1'b1;
    reg_addr_i <= `OFF_OFS;
    reg_wdata_i <= 16'h0030;
    @(posedge core_clk_i);
    mem_req_i <= 1'b0;
    reg_wr_i <= 1'b0;
    #1;
    chk(phys_addr_o, 20'h00023);
    chk(20'(phys_src_o), 20'(SRC_CORE));
    @(posedge core_clk_i);
    #1;
    chk(phys_addr_o, 20'h01030);
    chk(20'(phys_src_o), 20'(SRC_SOFT));
    @(posedge core_clk_i);
    #1;
    chk(20'(seen_count), 20'h00006);
    chk(last_addr, 20'h01030);
    finish_test();
  end

  // Cut a hang short
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule

// *** verif/exec_flags_props.sv ***
`timescale 1ns/100ps
`include "exec_flags_regs.svh"

// Checks flag and address outputs against their operands
module exec_flags_checker #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 20,
  parameter int REG_AW = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic op_valid_i,
  input wire exec_flags_pkg::alu_op_type op_code_i,
  input wire logic op_byte_i,
  input wire logic [DATA_W-1:0] op_a_i,
  input wire logic [DATA_W-1:0] op_b_i,
  input wire logic [DATA_W-1:0] result_o,
  input wire logic result_valid_o,
  input wire logic [DATA_W-1:0] flags_o,
  input wire logic mem_req_i,
  input wire logic [DATA_W-1:0] seg_i,
  input wire logic [DATA_W-1:0] off_i,
  input wire logic [ADDR_W-1:0] phys_addr_o,
  input wire logic phys_valid_o,
  input wire exec_flags_pkg::addr_src_type phys_src_o,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o
);
  import exec_flags_pkg::*;
  logic frz_reg; // Shadow of the freeze control bit
  logic frz_next;
  // Extra top bit holds carry or borrow
  wire [DATA_W:0] sum_w = {1'b0, op_a_i} + {1'b0, op_b_i};
  wire [DATA_W:0] dif_w = {1'b0, op_a_i} - {1'b0, op_b_i};
  wire cy_w = sum_w[DATA_W];
  wire bw_w = dif_w[DATA_W];
  wire aux_w = op_a_i[4] ^ op_b_i[4] ^ dif_w[4];
  wire [ADDR_W-1:0] addr_w = {seg_i, 4'h0} + ADDR_W'(off_i);
  wire ctrl_wr_w = reg_wr_i && (reg_addr_i == `OFF_CTRL);
  // Frozen flags must not trip the flag checks
  wire live_w = op_valid_i && !frz_reg;
  wire wide_w = live_w && !op_byte_i;
  assign frz_next = ctrl_wr_w ? reg_wdata_i[`CTRL_FREEZE_BIT] : frz_reg;

  // Track the freeze bit as software sets it
  always_ff @(posedge core_clk_i) begin
    frz_reg <= srst_i ? 1'b0 : frz_next;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_result_pulse: assert property (op_valid_i |=> result_valid_o)
    else $error("result valid missing after operation");
  a_carry_add: assert property (wide_w && op_code_i == OP_ADD
    |=> flags_o[`CARRY_OUT_FLAG_BIT] == $past(cy_w))
    else $error("carry flag wrong after word add");
  a_borrow_sub: assert property (wide_w && op_code_i == OP_SUB
    |=> flags_o[`CARRY_OUT_FLAG_BIT] == $past(bw_w))
    else $error("carry flag wrong after word subtract");
  a_aux_nibble: assert property (live_w && op_code_i == OP_SUB
    |=> flags_o[`AUX_FLAG_BIT] == $past(aux_w))
    else $error("aux flag wrong after subtract");
  a_parity_even: assert property (live_w && op_code_i != OP_CMP
    |=> flags_o[`PARITY_FLAG_BIT] == ~^result_o[7:0])
    else $error("parity flag disagrees with result");
  a_logic_clear: assert property (live_w && op_code_i inside
    {OP_AND, OP_OR, OP_XOR} |=> !flags_o[`CARRY_OUT_FLAG_BIT] ##0
    !flags_o[`AUX_FLAG_BIT])
    else $error("logic op left carry or aux set");
  a_phys_sum: assert property (mem_req_i |=> phys_valid_o
    && phys_addr_o == $past(addr_w))
    else $error("physical address not segment plus offset");
  a_phys_core: assert property (mem_req_i |=> phys_src_o == SRC_CORE)
    else $error("core reference not marked as core");
  a_phys_idle: assert property (!phys_valid_o |-> phys_src_o == SRC_IDLE)
    else $error("source shown while address not valid");

  c_compare: cover property (op_valid_i && op_code_i == OP_CMP);
  c_byte_op: cover property (live_w && op_byte_i);
  c_soft_addr: cover property (phys_valid_o && phys_src_o == SRC_SOFT);
endmodule

bind exec_flags_and_address_gen exec_flags_checker #(.DATA_W(DATA_W),
  .ADDR_W(ADDR_W), .REG_AW(REG_AW)) exec_flags_checker_i (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
  .op_code_i(op_code_i), .op_byte_i(op_byte_i), .op_a_i(op_a_i),
  .op_b_i(op_b_i), .result_o(result_o), .result_valid_o(result_valid_o),
  .flags_o(flags_o), .mem_req_i(mem_req_i), .seg_i(seg_i), .off_i(off_i),
  .phys_addr_o(phys_addr_o), .phys_valid_o(phys_valid_o),
  .phys_src_o(phys_src_o), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o));
